// file: bench/qsfc_assertions.sv
// Port checker for the frame controller
`timescale 1ns/1ps
// ==========
// Checker
module qsfc_assertions (
  // Clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // Watched ports
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdata,
  input wire        winReq,
  input wire [31:0] winAddr,
  input wire [7:0]  winRdata,
  input wire        winDone,
  input wire        sclk,
  input wire        csn,
  input wire [3:0]  ioOe
);
  reg pend;
  // One access at a time, so a plain flag tracks it
  always @(posedge clk_sys) begin
    if (!resetn)
      pend <= 1'b0;
    else if (winReq)
      pend <= 1'b1;
    else if (winDone)
      pend <= 1'b0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_done_single: assert property (winDone |=> !winDone)
    else $error("window done longer than one cycle");
  a_done_cause: assert property (winDone |-> pend)
    else $error("window done without a request");
  a_refuse_fast: assert property (winReq && winAddr[31:28] != 4'h8 |->
    ##[1:2] (winDone && winRdata == 8'h00))
    else $error("access outside window not refused at once");
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  a_wdata_idle: assert property (!winDone |-> winRdata == 8'h00)
    else $error("window data outside done cycle");
  a_cs_serving: assert property (winDone && !$past(winReq) && !$past(winReq, 2)
    |-> !csn)
    else $error("served access without chip select");
  a_lanes_idle: assert property (csn && $past(csn) |-> ioOe == 4'h0)
    else $error("lanes driven while deselected");
  a_sclk_quiet: assert property ($changed(sclk) |-> !csn || !$past(csn)
    || $past(regWrite) || $past(regWrite, 2) || $past(regWrite, 3))
    else $error("serial clock moved outside a frame");
endmodule // qsfc_assertions
bind qsfc_frame_ctrl qsfc_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .winReq(winReq),
  .winAddr(winAddr), .winRdata(winRdata), .winDone(winDone), .sclk(sclk),
  .csn(csn), .ioOe(ioOe));

// file: bench/qsfc_flash_model.sv
// Behavioural serial flash on the far side of the lanes
`timescale 1ns/1ps
// ==========
// Flash model
module qsfc_flash_model (
  // Pins from the controller
  input  wire        csn,
  input  wire        sclk,
  input  wire        mosi,
  input  wire [3:0]  ioOut,
  // Setup: bits per beat, beats before data, byte returned
  input  wire [2:0]  w,
  input  wire [7:0]  skip,
  input  wire [7:0]  rdByte,
  // Lane drive and what was heard
  output reg  [3:0]  drv,
  output reg  [63:0] cap,
  output reg  [7:0]  beats
);
  wire [7:0] idx = beats - skip;
  wire [7:0] tmp = rdByte << ((idx * w) % 8);
  initial drv = 4'h5;
  // Only CPOL 0 and CPHA 0: sclk is low when chip select falls
  always @(posedge sclk or negedge csn) begin
    if (!sclk)
      beats <= 8'h00;
    else begin
      beats <= beats + 8'h01;
      case (w)
        3'h1: cap <= {cap[62:0], mosi};
        3'h2: cap <= {cap[61:0], ioOut[1:0]};
        default: cap <= {cap[59:0], ioOut};
      endcase
    end
  end
  // Silent until the dummy beats are over; released lines keep moving
  always @(negedge sclk or posedge csn) begin
    if (!csn && beats >= skip)
      drv <= (w == 3'h1) ? {3'h0, tmp[7]} : (w == 3'h2) ? {2'h0, tmp[7:6]} : tmp[7:4];
    else
      drv <= ~drv;
  end
endmodule // qsfc_flash_model

// file: bench/qsfc_frame_ctrl_tb.sv
// Testbench of the frame controller
`timescale 1ns/1ps
`include "qsfc_defs.vh"
// ==========
// Bench
module qsfc_frame_ctrl_tb;
  reg         clk_sys = 1'b0;
  reg         resetn = 1'b0;
  reg  [7:0]  regAddr = 8'h00;
  reg  [31:0] regWdata = 32'h0;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg         winReq = 1'b0;
  reg         winWrite = 1'b0;
  reg  [31:0] winAddr = 32'h0;
  reg  [7:0]  winWdata = 8'h00;
  reg  [2:0]  w = 3'h1;
  reg  [7:0]  skip = 8'h00;
  reg  [7:0]  rdByte = 8'h5a;
  reg  [31:0] got;
  wire [31:0] regRdata;
  wire [7:0]  winRdata;
  wire        winDone;
  wire        sclk;
  wire        csn;
  wire        mosi;
  wire [3:0]  ioOut;
  wire [3:0]  ioOe;
  wire [3:0]  drv;
  wire [63:0] cap;
  wire [7:0]  beats;
  integer     fail_count = 0;
  integer     check_count = 0;
  integer     i;
  integer     n;
  always #20 clk_sys = ~clk_sys;
  // Wire level: controller wins where it drives
  wire [3:0] ioIn = (ioOe & ioOut) | (~ioOe & drv);
  qsfc_frame_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .winReq(winReq), .winWrite(winWrite), .winAddr(winAddr), .winWdata(winWdata),
    .winRdata(winRdata), .winDone(winDone), .sclk(sclk), .csn(csn), .mosi(mosi),
    .miso(drv[0]), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn));
  qsfc_flash_model flash (.csn(csn), .sclk(sclk), .mosi(mosi), .ioOut(ioOut), .w(w),
    .skip(skip), .rdByte(rdByte), .drv(drv), .cap(cap), .beats(beats));
  task chk(input [63:0] g, input [63:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a);
    begin
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 got = regRdata;
      @(posedge clk_sys);
    end
  endtask
  // Address and data stay put until the next access
  task win(input wr1, input [31:0] a, input [7:0] d);
    begin
      winAddr <= a;
      winWrite <= wr1;
      winWdata <= d;
      winReq <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      winReq <= 1'b0;
      #1;
      while (winDone !== 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      chk(winDone, 1'b1);
      got = {24'h0, winRdata};
      @(posedge clk_sys);
    end
  endtask
  task frame_end;
    begin
      n = 0;
      while (csn !== 1'b0 && n < 500) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk(n < 500, 1);
      while (csn !== 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk(csn, 1'b1);
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task complete_run;
    begin
      if (fail_count == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(`QSFC_OFS_MODE);
    chk(got, `QSFC_MODE_RST);
    rd(`QSFC_OFS_FRAME);
    chk(got, `QSFC_FRAME_RST);
    rd(8'h40);
    chk(got, 0);
    wr(`QSFC_OFS_FRAME, 32'hffffffff);
    rd(`QSFC_OFS_FRAME);
    chk(got, `QSFC_IF_MASK);
    wr(`QSFC_OFS_SCLK, 32'h0201);
    repeat (6) @(posedge clk_sys);
    chk(sclk, 1);
    wr(`QSFC_OFS_SCLK, 32'h0200);
    repeat (6) @(posedge clk_sys);
    chk(sclk, 0);
    win(0, 32'h80000000, 0);
    chk({n < 2, got}, {1'b1, 32'h0});
    wr(`QSFC_OFS_MODE, 32'h1);
    win(1, 32'h90000000, 8'h11);
    chk(n < 2, 1);
    wr(`QSFC_OFS_TXH, 32'hff);
    repeat (20) @(posedge clk_sys);
    chk(csn, 1);
    wr(`QSFC_OFS_CODE, 32'h00f0009c);
    wr(`QSFC_OFS_FRAME, 32'h10);
    frame_end;
    chk({beats, cap[7:0]}, 16'h089c);
    rd(`QSFC_OFS_STAT);
    chk(got[0], 1);
    rd(`QSFC_OFS_STAT);
    chk(got[0], 0);
    // Long clock-to-data gap, quad, 32-bit address
    w = 3'h4;
    wr(`QSFC_OFS_MODE, 32'h00300001);
    wr(`QSFC_OFS_ADDR, 32'h12345678);
    wr(`QSFC_OFS_FRAME, 32'h432);
    n = 0;
    while (sclk === 1'b0 && n < 200) begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk(n > 48, 1);
    frame_end;
    chk({beats, cap[39:0]}, {8'd10, 8'h9c, 32'h12345678});
    w = 3'h2;
    wr(`QSFC_OFS_FRAME, 32'h271);
    frame_end;
    chk({beats, cap[35:4]}, {8'd18, 8'h9c, 24'h345678});
    // Array read, dual, four dummy beats
    skip = 8'd20;
    wr(`QSFC_OFS_FRAME, 32'h000410b1);
    repeat (20) @(posedge clk_sys);
    chk(csn, 1);
    win(0, 32'h80000100, 0);
    chk({got, cap[47:16]}, {32'h5a, 8'h9c, 24'h000100});
    win(0, 32'h80000101, 0);
    chk({got, beats}, {32'h5a, 8'd28});
    win(0, 32'h80000200, 0);
    chk({beats, cap[47:16]}, {8'd24, 8'h9c, 24'h000200});
    wr(`QSFC_OFS_CTRL, 32'h1);
    frame_end;
    rd(`QSFC_OFS_STAT);
    chk(got[0], 1);
    wr(`QSFC_OFS_FRAME, 32'h000450b1);
    win(0, 32'h80000000, 0);
    chk(beats, 24);
    skip = 8'd16;
    win(0, 32'h80000300, 0);
    chk({got, beats}, {32'h5a, 8'd20});
    wr(`QSFC_OFS_CTRL, 32'h1);
    frame_end;
    // Other transfer kinds keep the first address only
    w = 3'h1;
    skip = 8'd32;
    for (i = 0; i < 4; i = i + 1) begin
      if (i != 1) begin
        wr(`QSFC_OFS_FRAME, 32'hb0 | (i << 12));
        win(i > 1, 32'h80000010, 8'hc3);
        win(i > 1, 32'h80000077, 8'h3c);
        chk(got, (i > 1) ? 32'h0 : 32'h5a);
        chk(cap[47:16], {8'h9c, 24'h000010});
        if (i > 1)
          chk(cap[15:0], 16'hc33c);
        wr(`QSFC_OFS_CTRL, 32'h1);
        frame_end;
      end
    end
    complete_run;
  end
endmodule // qsfc_frame_ctrl_tb

// file: common/qsfc_defs.vh
// Constants of the quad serial flash frame controller
// ==========================================================================
// What this block does
// - memory_mode_select picks plain serial master or serial memory operation.
// - In memory operation, window accesses at 0x8000_0000 carry the data.
// - In memory operation, transmit and receive holding registers move no payload.
// - Single lane drives mosi out and samples miso in.
// - Dual uses io lanes 0 and 1, quad uses four; direction turns per phase.
// - Frame order: command, address, option, dummy, data; each phase only when enabled.
// - Address is 24 bits, or 32 bits when address_length_select is set.
// - Option code is 1, 2, 4 or 8 bits; software matches it to lanes.
// - lane_select_field picks single, dual or quad for command, address, option, data.
// - Separate enable bits gate command, address, option and data phases.
// - In memory operation, frame setup write without data phase starts the frame at once.
// - Frame with data phase waits for the first window access.
// - transfer_type_field selects register read, array read, register write, array write.
// - Array read frames carry the access address; non-sequential reads start new frames.
// - Other transfer types use the first access address only, later ones ignored.
// - continuous_read_enable turns on continuous read operation.
// - In continuous read, frames after the first omit the command phase.
// - dummy_count_field dummy cycles come before the read data phase.
// - Address-only frames use address_holding_reg; data frames use the window address.
// - Frame without data raises frame_done_flag when it ends on the lanes.
// - last_transfer_bit after the final access ends a data frame and raises the flag.
// - Baud generator makes the serial clock; phase and polarity are selectable.
// - Mode register sets transfer, clock-to-data and chip select gap delays.
`ifndef QSFC_DEFS_VH
`define QSFC_DEFS_VH
// ==========================================================================
// Register offsets
`define QSFC_OFS_MODE   8'h00
`define QSFC_OFS_SCLK   8'h04
`define QSFC_OFS_TXH    8'h08
`define QSFC_OFS_RXH    8'h0c
`define QSFC_OFS_ADDR   8'h10
`define QSFC_OFS_CODE   8'h14
`define QSFC_OFS_FRAME  8'h18
`define QSFC_OFS_STAT   8'h1c
`define QSFC_OFS_CTRL   8'h20
// ==========================================================================
// Fields
`define QSFC_MR_SMM     0
`define QSFC_MR_XFER    15:8
`define QSFC_MR_CLKD    23:16
`define QSFC_MR_CSD     31:24
`define QSFC_SC_CPOL    0
`define QSFC_SC_CPHA    1
`define QSFC_SC_BAUD    15:8
`define QSFC_IF_LANES   2:0
`define QSFC_IF_CMDEN   4
`define QSFC_IF_ADREN   5
`define QSFC_IF_OPTION_SEND_ENABLE   6
`define QSFC_IF_DATEN   7
`define QSFC_IF_OPTION_LENGTH_FIELD    9:8
`define QSFC_IF_ADRL    10
`define QSFC_IF_TTYPE   13:12
`define QSFC_IF_CRM     14
`define QSFC_IF_NDUM    20:16
`define QSFC_IF_MASK    32'h001f77f7
`define QSFC_IC_CMD     7:0
`define QSFC_IC_OPT     23:16
`define QSFC_CR_LAST    0
// ==========================================================================
// Codes and reset values
`define QSFC_LANES_DUAL 3'h1
`define QSFC_LANES_QUAD 3'h2
`define QSFC_TT_RDMEM   2'h1
`define QSFC_WIN_TOP    4'h8
`define QSFC_MODE_RST   32'h00000000
`define QSFC_SCLK_RST   16'h0000
`define QSFC_FRAME_RST  32'h00000000
`define QSFC_BYTE_BITS  6'd8
`define QSFC_ADR24_BITS 6'd24
`define QSFC_ADR32_BITS 6'd32
`endif

// file: logic/qsfc_baud_gen.v
// Baud tick generator for the serial clock
`timescale 1ns/1ps
module qsfc_baud_gen (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Control
  input  wire       run,
  input  wire [7:0] div,
  // Half-period tick
  output reg        tick
);
  reg [8:0] cnt;

  // Period is div+2 so pin registers settle before each edge
  always @(posedge clk_sys) begin
    if (!resetn || !run) begin
      cnt  <= 9'h000;
      tick <= 1'b0;
    end else if (cnt == {1'b0, div} + 9'h001) begin
      cnt  <= 9'h000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 9'h001;
      tick <= 1'b0;
    end
  end
endmodule // qsfc_baud_gen

// file: logic/qsfc_frame_ctrl.v
// Quad serial flash frame controller top
`timescale 1ns/1ps
`include "qsfc_defs.vh"
module qsfc_frame_ctrl (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdata,
  // Memory window
  input  wire        winReq,
  input  wire        winWrite,
  input  wire [31:0] winAddr,
  input  wire [7:0]  winWdata,
  output reg  [7:0]  winRdata,
  output reg         winDone,
  // Serial flash pins
  output reg         sclk,
  output reg         csn,
  output reg         mosi,
  input  wire        miso,
  output reg  [3:0]  ioOut,
  output reg  [3:0]  ioOe,
  input  wire [3:0]  ioIn
);
  // ==========================================================================
  // States
  localparam S_IDLE = 9'h001;
  localparam S_DLY  = 9'h002;
  localparam S_CMD  = 9'h004;
  localparam S_ADDR = 9'h008;
  localparam S_OPT  = 9'h010;
  localparam S_DUM  = 9'h020;
  localparam S_DATA = 9'h040;
  localparam S_WAIT = 9'h080;
  localparam S_END  = 9'h100;

  // ==========================================================================
  // Functions
  function [8:0] pickPhase;
    input [4:0] present;
    input [2:0] from;
    integer i;
    reg found;
    begin
      pickPhase = S_END;
      found = 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        if (!found && i >= from && present[i]) begin
          found = 1'b1;
          pickPhase = S_CMD << i;
        end
      end
    end
  endfunction

  function [2:0] laneCount;
    input [2:0] sel;
    begin
      if (sel == `QSFC_LANES_QUAD)
        laneCount = 3'h4;
      else if (sel == `QSFC_LANES_DUAL)
        laneCount = 3'h2;
      else
        laneCount = 3'h1;
    end
  endfunction

  function [7:0] shiftIn;
    input [7:0] cur;
    input [2:0] w;
    input [4:0] pins;
    begin
      if (w == 3'h4)
        shiftIn = {cur[3:0], pins[4:1]};
      else if (w == 3'h2)
        shiftIn = {cur[5:0], pins[2:1]};
      else
        shiftIn = {cur[6:0], pins[0]};
    end
  endfunction

  // ==========================================================================
  // Registers
  reg [31:0] modeCfg;
  reg [15:0] sclkCfg;
  reg [31:0] addrHold;
  reg [31:0] cmdCode;
  reg [31:0] frameSetup;
  reg [7:0]  rxHold;
  reg        frameDone;
  reg        lastReq;
  reg        armed;
  reg        goFrame;
  reg        crmActive;
  reg        accPend;
  reg        accWrite;
  reg [31:0] accAddr;
  reg [7:0]  accData;
  reg [31:0] expAddr;
  reg [31:0] frameAddr;
  reg [8:0]  state;
  reg [8:0]  dlyRet;
  reg [7:0]  dlyCnt;
  reg [2:0]  curW;
  reg        rxMode;
  reg        spiXfer;
  reg        beatHalf;
  reg [5:0]  bitsLeft;
  reg [31:0] txShift;
  reg [7:0]  rxShift;

  // ==========================================================================
  // Pin synchroniser and baud generator
  wire [4:0] pinSync;
  wire       tick;
  wire       shifting = |(state & (S_CMD | S_ADDR | S_OPT | S_DUM | S_DATA));

  qsfc_sync2 uSync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     ({ioIn, miso}),
    .dout    (pinSync)
  );

  qsfc_baud_gen uBaud (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (shifting),
    .div     (sclkCfg[`QSFC_SC_BAUD]),
    .tick    (tick)
  );

  // ==========================================================================
  // Phase selection
  wire       memMode  = modeCfg[`QSFC_MR_SMM];
  wire [1:0] tType    = frameSetup[`QSFC_IF_TTYPE];
  wire       cpol     = sclkCfg[`QSFC_SC_CPOL];
  wire       cpha     = sclkCfg[`QSFC_SC_CPHA];
  wire       payload_phase_enable   = frameSetup[`QSFC_IF_DATEN];
  wire       crmRead  = frameSetup[`QSFC_IF_CRM] && tType == `QSFC_TT_RDMEM;
  wire       skipCmd  = crmRead && crmActive;
  wire [4:0] present  = {payload_phase_enable, frameSetup[`QSFC_IF_NDUM] != 5'h00,
                         frameSetup[`QSFC_IF_OPTION_SEND_ENABLE], frameSetup[`QSFC_IF_ADREN],
                         frameSetup[`QSFC_IF_CMDEN] && !skipCmd};
  wire [31:0] startAddr = payload_phase_enable ? accAddr : addrHold;
  wire [31:0] phAddr    = (state == S_IDLE) ? startAddr : frameAddr;
  wire [2:0] stepW    = (state == S_DUM) ? 3'h1 : curW;
  wire       sampling = (state == S_DATA) && rxMode;
  wire [7:0] rxNow    = shiftIn(rxShift, curW, pinSync);
  wire [7:0] rxFinal  = cpha ? rxNow : rxShift;
  wire       txSend   = |(state & (S_CMD | S_ADDR | S_OPT)) ||
                        (state == S_DATA && (!rxMode || spiXfer));
  reg  [2:0] curIdx;
  reg [31:0] loadShift;
  reg  [5:0] loadBits;

  always @* begin
    case (state)
      S_ADDR:  curIdx = 3'h1;
      S_OPT:   curIdx = 3'h2;
      S_DUM:   curIdx = 3'h3;
      S_DATA:  curIdx = 3'h4;
      default: curIdx = 3'h0;
    endcase
  end

  wire [2:0] fromIdx = (state == S_IDLE) ? 3'h0 : curIdx + 3'h1;
  wire [8:0] nextPh  = pickPhase(present, fromIdx);

  always @* begin
    loadShift = 32'h00000000;
    loadBits  = 6'd0;
    case (nextPh)
      S_CMD: begin
        loadShift = {cmdCode[`QSFC_IC_CMD], 24'h000000};
        loadBits  = `QSFC_BYTE_BITS;
      end
      S_ADDR: begin
        if (frameSetup[`QSFC_IF_ADRL]) begin
          loadShift = phAddr;
          loadBits  = `QSFC_ADR32_BITS;
        end else begin
          loadShift = {phAddr[23:0], 8'h00};
          loadBits  = `QSFC_ADR24_BITS;
        end
      end
      S_OPT: begin
        loadShift = {cmdCode[`QSFC_IC_OPT], 24'h000000};
        loadBits  = 6'd1 << frameSetup[`QSFC_IF_OPTION_LENGTH_FIELD];
      end
      S_DUM: begin
        loadBits  = {1'b0, frameSetup[`QSFC_IF_NDUM]};
      end
      S_DATA: begin
        loadShift = {accData, 24'h000000};
        loadBits  = `QSFC_BYTE_BITS;
      end
      default: begin
        loadBits  = 6'd0;
      end
    endcase
  end

  // ==========================================================================
  // Register writes, window requests and frame engine
  wire wrFrame = regWrite && regAddr == `QSFC_OFS_FRAME;
  wire inWin   = winAddr[31:28] == `QSFC_WIN_TOP;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      modeCfg    <= `QSFC_MODE_RST;
      sclkCfg    <= `QSFC_SCLK_RST;
      addrHold   <= 32'h00000000;
      cmdCode    <= 32'h00000000;
      frameSetup <= `QSFC_FRAME_RST;
      rxHold     <= 8'h00;
      frameDone  <= 1'b0;
      lastReq    <= 1'b0;
      armed      <= 1'b0;
      goFrame    <= 1'b0;
      crmActive  <= 1'b0;
      accPend    <= 1'b0;
      accWrite   <= 1'b0;
      accAddr    <= 32'h00000000;
      accData    <= 8'h00;
      expAddr    <= 32'h00000000;
      frameAddr  <= 32'h00000000;
      state      <= S_IDLE;
      dlyRet     <= S_IDLE;
      dlyCnt     <= 8'h00;
      curW       <= 3'h1;
      rxMode     <= 1'b0;
      spiXfer    <= 1'b0;
      beatHalf   <= 1'b0;
      bitsLeft   <= 6'd0;
      txShift    <= 32'h00000000;
      rxShift    <= 8'h00;
      winDone    <= 1'b0;
      winRdata   <= 8'h00;
      sclk       <= 1'b0;
      csn        <= 1'b1;
    end else begin
      winDone <= 1'b0;
      // Read byte stands only beside its done pulse
      winRdata <= 8'h00;
      if (regWrite) begin
        case (regAddr)
          `QSFC_OFS_MODE: modeCfg  <= regWdata;
          `QSFC_OFS_SCLK: sclkCfg  <= regWdata[15:0];
          `QSFC_OFS_ADDR: addrHold <= regWdata;
          `QSFC_OFS_CODE: cmdCode  <= regWdata;
          `QSFC_OFS_CTRL: begin
            if (regWdata[`QSFC_CR_LAST])
              lastReq <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (wrFrame) begin
        frameSetup <= regWdata & `QSFC_IF_MASK;
        crmActive  <= 1'b0;
        armed      <= memMode && regWdata[`QSFC_IF_DATEN];
        goFrame    <= memMode && !regWdata[`QSFC_IF_DATEN];
      end
      // Clear on read; a set later in this block still wins
      if (regRead && regAddr == `QSFC_OFS_STAT)
        frameDone <= 1'b0;
      if (winReq) begin
        if (memMode && inWin && !accPend) begin
          accPend  <= 1'b1;
          accWrite <= winWrite;
          accAddr  <= {4'h0, winAddr[27:0]};
          accData  <= winWdata;
        end else begin
          winDone  <= 1'b1;
          winRdata <= 8'h00;
        end
      end
      case (state)
        S_IDLE: begin
          sclk     <= cpol;
          spiXfer  <= 1'b0;
          beatHalf <= 1'b0;
          if ((armed && accPend) || goFrame) begin
            goFrame   <= 1'b0;
            csn       <= 1'b0;
            frameAddr <= startAddr;
            expAddr   <= accAddr;
            txShift   <= loadShift;
            bitsLeft  <= loadBits;
            curW      <= laneCount(frameSetup[`QSFC_IF_LANES]);
            rxMode    <= !tType[1];
            dlyCnt    <= modeCfg[`QSFC_MR_CLKD];
            dlyRet    <= nextPh;
            state     <= S_DLY;
          end else if (armed && lastReq) begin
            armed     <= 1'b0;
            lastReq   <= 1'b0;
            frameDone <= 1'b1;
          end else if (regWrite && regAddr == `QSFC_OFS_TXH && !memMode) begin
            spiXfer  <= 1'b1;
            csn      <= 1'b0;
            txShift  <= {regWdata[7:0], 24'h000000};
            bitsLeft <= `QSFC_BYTE_BITS;
            curW     <= 3'h1;
            rxMode   <= 1'b1;
            dlyCnt   <= modeCfg[`QSFC_MR_CLKD];
            dlyRet   <= S_DATA;
            state    <= S_DLY;
          end
        end
        S_DLY: begin
          if (dlyCnt == 8'h00)
            state <= dlyRet;
          else
            dlyCnt <= dlyCnt - 8'h01;
        end
        S_CMD, S_ADDR, S_OPT, S_DUM, S_DATA: begin
          if (tick) begin
            sclk <= ~sclk;
            if (!beatHalf) begin
              beatHalf <= 1'b1;
              if (!cpha && sampling)
                rxShift <= rxNow;
            end else begin
              beatHalf <= 1'b0;
              if (cpha && sampling)
                rxShift <= rxNow;
              txShift <= txShift << stepW;
              if (bitsLeft > {3'b000, stepW}) begin
                bitsLeft <= bitsLeft - {3'b000, stepW};
              end else if (state == S_DATA) begin
                accPend  <= 1'b0;
                winDone  <= !spiXfer;
                winRdata <= (rxMode && !spiXfer) ? rxFinal : 8'h00;
                if (spiXfer) begin
                  rxHold <= rxFinal;
                  state  <= S_END;
                end else begin
                  expAddr <= accAddr + 32'h00000001;
                  dlyCnt  <= modeCfg[`QSFC_MR_XFER];
                  dlyRet  <= S_WAIT;
                  state   <= S_DLY;
                end
              end else begin
                state    <= nextPh;
                txShift  <= loadShift;
                bitsLeft <= loadBits;
              end
            end
          end
        end
        S_WAIT: begin
          if (accPend) begin
            if (tType == `QSFC_TT_RDMEM && !accWrite && accAddr != expAddr) begin
              state <= S_END;
            end else begin
              txShift  <= {accData, 24'h000000};
              bitsLeft <= `QSFC_BYTE_BITS;
              state    <= S_DATA;
            end
          end else if (lastReq) begin
            lastReq <= 1'b0;
            armed   <= 1'b0;
            state   <= S_END;
          end
        end
        S_END: begin
          csn   <= 1'b1;
          sclk  <= cpol;
          if (!spiXfer && !(armed && accPend))
            frameDone <= 1'b1;
          if (!spiXfer && crmRead && payload_phase_enable)
            crmActive <= 1'b1;
          dlyCnt <= modeCfg[`QSFC_MR_CSD];
          dlyRet <= S_IDLE;
          state  <= S_DLY;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Lane drivers, registered; released while receiving or in dummy cycles
  always @(posedge clk_sys) begin
    if (!resetn) begin
      mosi  <= 1'b0;
      ioOut <= 4'h0;
      ioOe  <= 4'h0;
    end else begin
      mosi <= txSend && curW == 3'h1 && txShift[31];
      if (txSend && curW == 3'h4) begin
        ioOut <= txShift[31:28];
        ioOe  <= 4'hf;
      end else if (txSend && curW == 3'h2) begin
        ioOut <= {2'b00, txShift[31:30]};
        ioOe  <= 4'h3;
      end else begin
        ioOut <= 4'h0;
        ioOe  <= 4'h0;
      end
    end
  end

  // ==========================================================================
  // Register read data, valid one cycle after the strobe only
  always @(posedge clk_sys) begin
    if (!resetn || !regRead) begin
      regRdata <= 32'h00000000;
    end else begin
      case (regAddr)
        `QSFC_OFS_MODE:  regRdata <= modeCfg;
        `QSFC_OFS_SCLK:  regRdata <= {16'h0000, sclkCfg};
        `QSFC_OFS_RXH:   regRdata <= {24'h000000, rxHold};
        `QSFC_OFS_ADDR:  regRdata <= addrHold;
        `QSFC_OFS_CODE:  regRdata <= cmdCode;
        `QSFC_OFS_FRAME: regRdata <= frameSetup;
        `QSFC_OFS_STAT:  regRdata <= {29'h0, armed, state != S_IDLE, frameDone};
        default:         regRdata <= 32'h00000000;
      endcase
    end
  end
endmodule // qsfc_frame_ctrl

// file: logic/qsfc_sync2.v
// Two-stage synchroniser for the serial input pins
`timescale 1ns/1ps
module qsfc_sync2 (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       resetn,
  // Pins in, synchronised out
  input  wire [4:0] din,
  output reg  [4:0] dout
);
  reg [4:0] stage1;

  always @(posedge clk_sys) begin
    if (!resetn) begin
      stage1 <= 5'h00;
      dout   <= 5'h00;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // qsfc_sync2
